// ### sync_mem_pkg.sv
// Shared constants and types for the synchronous memory port controller.
package sync_mem_pkg;
  localparam int NUM_SPACES_DEF = 4;
  localparam int ADDR_W_DEF     = 20;
  localparam int BE_W_DEF       = 4;
  localparam int DATA_W         = 32;
  localparam int CTRL_W         = 7;

  localparam logic [7:0] OFS_SPACE_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CLK_DIV     = 8'h10;
  localparam logic [7:0] OFS_ADDR        = 8'h14;
  localparam logic [7:0] OFS_WDATA       = 8'h18;
  localparam logic [7:0] OFS_CMD         = 8'h1C;
  localparam logic [7:0] OFS_STATUS      = 8'h20;
  localparam logic [7:0] OFS_RDATA       = 8'h24;

  localparam int RL_LSB        = 0;
  localparam int WL_LSB        = 2;
  localparam int CHIP_ENABLE_EXTEND_BIT     = 4;
  localparam int STROBE_BIT    = 5;
  localparam int CLKSEL_BIT    = 6;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_SPACE_LSB = 1;
  localparam int CMD_BE_LSB    = 4;
  localparam int STAT_BUSY_BIT = 0;

  localparam logic [CTRL_W-1:0] SPACE_CTRL_RST = 7'h00;
  localparam logic [1:0]        CLK_DIV_RST    = 2'h0;

  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;

  typedef logic [CTRL_W-1:0] space_ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ARM    = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_DESEL  = 4'h8
  } port_state_t;
endpackage

// ### clk_tick_if.sv
// Carrier between the controller and its output clock generator.
interface clk_tick_if;
  logic [1:0] div_code;
  logic       full_tick;
  logic       div_tick;
  logic       full_clk;
  logic       div_clk;
  modport gen  (input div_code, output full_tick, div_tick, full_clk, div_clk);
  modport user (output div_code, input full_tick, div_tick, full_clk, div_clk);
endinterface

// ### out_clock_gen.sv
// Full-rate and divided interface clocks with their rising-edge ticks.
module out_clock_gen (
  // Clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // Clocks and ticks
  clk_tick_if.gen   ct
);
  logic       full_clk_r;
  logic       full_clk_nxt;
  logic       div_clk_r;
  logic       div_clk_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] half_m1;

  // Half period in pclk cycles is N, so the divided clock has period 2N.
  always_comb begin
    case (ct.div_code)
      sync_mem_pkg::DIV_BY1: half_m1 = 2'h0;
      sync_mem_pkg::DIV_BY2: half_m1 = 2'h1;
      default:               half_m1 = 2'h3;
    endcase
    full_clk_nxt = ~full_clk_r;
    if (cnt_r >= half_m1) begin
      cnt_nxt     = 2'h0;
      div_clk_nxt = ~div_clk_r;
    end else begin
      cnt_nxt     = cnt_r + 2'h1;
      div_clk_nxt = div_clk_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_clk_r <= 1'b0;
      div_clk_r  <= 1'b0;
      cnt_r      <= 2'h0;
    end else begin
      full_clk_r <= full_clk_nxt;
      div_clk_r  <= div_clk_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  assign ct.full_clk  = full_clk_r;
  assign ct.div_clk   = div_clk_r;
  assign ct.full_tick = ~full_clk_r;
  assign ct.div_tick  = ~div_clk_r & (cnt_r >= half_m1);
endmodule

// ### sync_memory_port_control.sv
// Synchronous memory port controller with an APB register slave.
//
// Contract
// - Read data taken 0..3 cycles after command.
// - Write data driven 0..3 cycles after command.
// - Extension off: chip enable drops after command.
// - Extension on: chip enable follows output enable on reads.
// - Strobe select 0: address strobe, deselect cycle.
// - Strobe select 1: read enable, no deselect.
// - Interface runs on full or divided clock.
// - Control pins act as strobe, enables.
// - Divided clock is input rate over 2/4/8.
module sync_memory_port_control #(
  parameter int NUM_SPACES = sync_mem_pkg::NUM_SPACES_DEF,
  parameter int ADDR_W     = sync_mem_pkg::ADDR_W_DEF,
  parameter int BE_W       = sync_mem_pkg::BE_W_DEF
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Memory clocks
  output logic                           full_rate_out_clock,
  output logic                           divided_out_clock,
  // Memory control and address
  output logic      [NUM_SPACES-1:0]     space_chip_enable_n,
  output logic      [BE_W-1:0]           byte_enable_n,
  output logic      [ADDR_W-1:0]         ext_address,
  output logic                           addr_strobe_or_read_en_n,
  output logic                           sync_output_enable_n,
  output logic                           sync_write_enable_n,
  // Memory data pins
  input  wire logic [31:0]               ext_data_i,
  output logic      [31:0]               ext_data_o,
  output logic                           ext_data_oe
);
  typedef sync_mem_pkg::space_ctrl_t ctrl_t;
  typedef sync_mem_pkg::port_state_t st_t;

  clk_tick_if ct ();
  out_clock_gen u_clk (.pclk(pclk), .presetn(presetn), .ct(ct));

  // APB slave: one wait cycle, so every transfer answers in its second
  // access cycle and the read mux stays off the critical path.
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        acc, wr_fire, hit, sp_hit;
  ctrl_t       space_ctrl_r [NUM_SPACES];
  logic [1:0]  clk_div_r, clk_div_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  st_t         state_r, state_nxt;
  logic [1:0]  cap_pipe_r, cap_pipe_nxt;

  assign acc     = psel & penable & ~pready_r;
  assign wr_fire = psel & penable & pready_r & pwrite;
  assign sp_hit  = (paddr < sync_mem_pkg::OFS_CLK_DIV) &&
                   (32'(paddr[3:2]) < NUM_SPACES);
  assign hit     = (paddr[1:0] == 2'h0) &&
                   (sp_hit || ((paddr >= sync_mem_pkg::OFS_CLK_DIV) &&
                               (paddr <= sync_mem_pkg::OFS_RDATA)));

  always_comb begin
    pready_nxt  = acc;
    pslverr_nxt = acc & ~hit;
    prdata_nxt  = 32'h0;
    if (acc && !pwrite) begin
      if (sp_hit) begin
        prdata_nxt = 32'(space_ctrl_r[paddr[3:2]]);
      end else begin
        case (paddr)
          sync_mem_pkg::OFS_CLK_DIV: prdata_nxt = 32'(clk_div_r);
          sync_mem_pkg::OFS_ADDR:    prdata_nxt = 32'(addr_r);
          sync_mem_pkg::OFS_WDATA:   prdata_nxt = wdata_r;
          sync_mem_pkg::OFS_STATUS:
            prdata_nxt = 32'((state_r != sync_mem_pkg::ST_IDLE) ||
                             (|cap_pipe_r)) << sync_mem_pkg::STAT_BUSY_BIT;
          sync_mem_pkg::OFS_RDATA:   prdata_nxt = rdata_r;
          default:                   prdata_nxt = 32'h0;
        endcase
      end
    end
    clk_div_nxt = (wr_fire && paddr == sync_mem_pkg::OFS_CLK_DIV) ?
                  pwdata[1:0] : clk_div_r;
    addr_nxt    = (wr_fire && paddr == sync_mem_pkg::OFS_ADDR) ?
                  pwdata[ADDR_W-1:0] : addr_r;
    wdata_nxt   = (wr_fire && paddr == sync_mem_pkg::OFS_WDATA) ?
                  pwdata : wdata_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      clk_div_r <= sync_mem_pkg::CLK_DIV_RST;
      addr_r    <= '0;
      wdata_r   <= 32'h0;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
      clk_div_r <= clk_div_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
    end
  end

  for (genvar g = 0; g < NUM_SPACES; g++) begin : g_space
    ctrl_t ctrl_nxt;
    always_comb begin
      ctrl_nxt = space_ctrl_r[g];
      if (wr_fire && sp_hit && 32'(paddr[3:2]) == g) begin
        ctrl_nxt = pwdata[sync_mem_pkg::CTRL_W-1:0];
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        space_ctrl_r[g] <= sync_mem_pkg::SPACE_CTRL_RST;
      end else begin
        space_ctrl_r[g] <= ctrl_nxt;
      end
    end
  end

  assign ct.div_code = clk_div_r;

  // Read data pins are double-registered before use, so the capture waits
  // two cycles after its interface edge to take the value of that edge.
  // Busy stays up meanwhile, so a poll never returns stale read data.
  logic [31:0] din_meta_r, din_sync_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta_r <= 32'h0;
      din_sync_r <= 32'h0;
    end else begin
      din_meta_r <= ext_data_i;
      din_sync_r <= din_meta_r;
    end
  end

  // Access engine; after leaving idle it steps only on ticks of the selected interface clock.
  logic [2:0] lat_r, lat_nxt, k;
  ctrl_t      act_ctrl_r, act_ctrl_nxt;
  logic       act_wr_r, act_wr_nxt, tick, cmd_fire, done;
  logic [1:0] act_sp_r, act_sp_nxt, rl, wl;
  logic [BE_W-1:0] act_be_r, act_be_nxt, be_n_r, be_n_nxt;
  logic [NUM_SPACES-1:0] ce_n_r, ce_n_nxt;
  logic [ADDR_W-1:0] xaddr_r, xaddr_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic strobe_n_r, strobe_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic doe_r, doe_nxt;

  assign cmd_fire = wr_fire && paddr == sync_mem_pkg::OFS_CMD;
  assign rl   = act_ctrl_r[sync_mem_pkg::RL_LSB +: 2];
  assign wl   = act_ctrl_r[sync_mem_pkg::WL_LSB +: 2];
  assign tick = act_ctrl_r[sync_mem_pkg::CLKSEL_BIT] ?
                ct.div_tick : ct.full_tick;
  assign k    = lat_r + 3'h1;

  always_comb begin
    state_nxt    = state_r;
    lat_nxt      = lat_r;
    act_ctrl_nxt = act_ctrl_r;
    act_wr_nxt   = act_wr_r;
    act_sp_nxt   = act_sp_r;
    act_be_nxt   = act_be_r;
    ce_n_nxt     = ce_n_r;
    be_n_nxt     = be_n_r;
    xaddr_nxt    = xaddr_r;
    dout_nxt     = dout_r;
    strobe_n_nxt = strobe_n_r;
    oe_n_nxt     = oe_n_r;
    we_n_nxt     = we_n_r;
    doe_nxt      = doe_r;
    cap_pipe_nxt = {cap_pipe_r[0], 1'b0};
    rdata_nxt    = cap_pipe_r[1] ? din_sync_r : rdata_r;
    done         = 1'b0;
    case (state_r)
      sync_mem_pkg::ST_IDLE: begin
        // A command written while the engine is not in idle is dropped.
        if (cmd_fire &&
            32'(pwdata[sync_mem_pkg::CMD_SPACE_LSB +: 2]) < NUM_SPACES) begin
          act_sp_nxt   = pwdata[sync_mem_pkg::CMD_SPACE_LSB +: 2];
          act_wr_nxt   = pwdata[sync_mem_pkg::CMD_WRITE_BIT];
          act_be_nxt   = pwdata[sync_mem_pkg::CMD_BE_LSB +: BE_W];
          act_ctrl_nxt = space_ctrl_r[act_sp_nxt];
          state_nxt    = sync_mem_pkg::ST_ARM;
        end
      end
      sync_mem_pkg::ST_ARM: begin
        if (tick) begin
          ce_n_nxt     = ~(NUM_SPACES'(1) << act_sp_r);
          be_n_nxt     = ~act_be_r;
          xaddr_nxt    = addr_r;
          dout_nxt     = wdata_r;
          strobe_n_nxt = 1'b0;
          oe_n_nxt     = act_wr_r;
          we_n_nxt     = ~act_wr_r;
          doe_nxt      = act_wr_r && wl == 2'h0;
          lat_nxt      = 3'h0;
          state_nxt    = sync_mem_pkg::ST_ACTIVE;
        end
      end
      sync_mem_pkg::ST_ACTIVE: begin
        if (tick) begin
          lat_nxt      = k;
          strobe_n_nxt = 1'b1;
          we_n_nxt     = 1'b1;
          if (!act_ctrl_r[sync_mem_pkg::CHIP_ENABLE_EXTEND_BIT] || act_wr_r) begin
            ce_n_nxt = '1;
          end
          if (!act_wr_r) begin
            if (k == {1'b0, rl} + 3'h1) begin
              cap_pipe_nxt[0] = 1'b1;
              oe_n_nxt  = 1'b1;
              ce_n_nxt  = '1;
              done      = 1'b1;
            end
          end else begin
            if (k == {1'b0, wl}) begin
              doe_nxt = 1'b1;
            end
            if (k == {1'b0, wl} + 3'h1) begin
              doe_nxt = 1'b0;
              done    = 1'b1;
            end
          end
          if (done) begin
            state_nxt = act_ctrl_r[sync_mem_pkg::STROBE_BIT] ?
                        sync_mem_pkg::ST_IDLE :
                        sync_mem_pkg::ST_DESEL;
          end
        end
      end
      sync_mem_pkg::ST_DESEL: begin
        if (tick) begin
          state_nxt = sync_mem_pkg::ST_IDLE;
        end
      end
      default: state_nxt = sync_mem_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= sync_mem_pkg::ST_IDLE;
      lat_r      <= 3'h0;
      act_ctrl_r <= sync_mem_pkg::SPACE_CTRL_RST;
      act_wr_r   <= 1'b0;
      act_sp_r   <= 2'h0;
      act_be_r   <= '0;
      ce_n_r     <= '1;
      be_n_r     <= '1;
      xaddr_r    <= '0;
      dout_r     <= 32'h0;
      strobe_n_r <= 1'b1;
      oe_n_r     <= 1'b1;
      we_n_r     <= 1'b1;
      doe_r      <= 1'b0;
      rdata_r    <= 32'h0;
      cap_pipe_r <= 2'h0;
    end else begin
      state_r    <= state_nxt;
      lat_r      <= lat_nxt;
      act_ctrl_r <= act_ctrl_nxt;
      act_wr_r   <= act_wr_nxt;
      act_sp_r   <= act_sp_nxt;
      act_be_r   <= act_be_nxt;
      ce_n_r     <= ce_n_nxt;
      be_n_r     <= be_n_nxt;
      xaddr_r    <= xaddr_nxt;
      dout_r     <= dout_nxt;
      strobe_n_r <= strobe_n_nxt;
      oe_n_r     <= oe_n_nxt;
      we_n_r     <= we_n_nxt;
      doe_r      <= doe_nxt;
      rdata_r    <= rdata_nxt;
      cap_pipe_r <= cap_pipe_nxt;
    end
  end

  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign full_rate_out_clock      = ct.full_clk;
  assign divided_out_clock        = ct.div_clk;
  assign space_chip_enable_n      = ce_n_r;
  assign byte_enable_n            = be_n_r;
  assign ext_address              = xaddr_r;
  assign addr_strobe_or_read_en_n = strobe_n_r;
  assign sync_output_enable_n     = oe_n_r;
  assign sync_write_enable_n      = we_n_r;
  assign ext_data_o               = dout_r;
  assign ext_data_oe              = doe_r;

  // Helper logic read only by the checks below.
  logic [2:0] h_cnt_r;
  logic [3:0] div_per_r;
  logic       div_prev_r, div_seen_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_cnt_r    <= 3'h0;
      div_per_r  <= 4'h0;
      div_prev_r <= 1'b0;
      div_seen_r <= 1'b0;
    end else begin
      if (state_r == sync_mem_pkg::ST_ARM && tick) h_cnt_r <= 3'h0;
      else if (tick && h_cnt_r != 3'h7) h_cnt_r <= h_cnt_r + 3'h1;
      div_prev_r <= ct.div_clk;
      div_per_r  <= (ct.div_clk & ~div_prev_r) ? 4'h0 : div_per_r + 4'h1;
      if (clk_div_nxt != clk_div_r) div_seen_r <= 1'b0;
      else if (ct.div_clk & ~div_prev_r) div_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence launch_s;
    state_r == sync_mem_pkg::ST_ARM && tick;
  endsequence
  sequence finish_s;
    state_r == sync_mem_pkg::ST_ACTIVE && tick && done;
  endsequence

  chk_read_capture: assert property (
    finish_s and !act_wr_r |-> h_cnt_r == {1'b0, rl})
    else $error("read data captured at wrong latency");
  chk_write_drive: assert property (
    $rose(ext_data_oe) |-> h_cnt_r == {1'b0, wl} && act_wr_r)
    else $error("write data driven at wrong latency");
  chk_ce_release: assert property (
    state_r == sync_mem_pkg::ST_ACTIVE && tick &&
    !act_ctrl_r[sync_mem_pkg::CHIP_ENABLE_EXTEND_BIT] |=> &space_chip_enable_n)
    else $error("chip enable held after command");
  chk_ce_follows_oe: assert property (
    launch_s ##1 (act_ctrl_r[sync_mem_pkg::CHIP_ENABLE_EXTEND_BIT] && !act_wr_r) |->
    (&space_chip_enable_n) == sync_output_enable_n)
    else $error("chip enable not following output enable");
  chk_deselect_gap: assert property (
    finish_s and !act_ctrl_r[sync_mem_pkg::STROBE_BIT] |=>
    state_r == sync_mem_pkg::ST_DESEL && addr_strobe_or_read_en_n &&
    (&space_chip_enable_n))
    else $error("missing deselect cycle");
  chk_no_deselect: assert property (
    finish_s and act_ctrl_r[sync_mem_pkg::STROBE_BIT] |=>
    state_r == sync_mem_pkg::ST_IDLE)
    else $error("deselect inserted in read enable mode");
  chk_pin_timing: assert property (
    $changed(ext_address) |-> $past(tick) &&
    (act_ctrl_r[sync_mem_pkg::CLKSEL_BIT] ?
     $rose(divided_out_clock) : $rose(full_rate_out_clock)))
    else $error("pins moved off the selected clock edge");
  chk_strobe_roles: assert property (
    launch_s |=> !addr_strobe_or_read_en_n &&
    (sync_output_enable_n != sync_write_enable_n))
    else $error("control pins misused");
  chk_strobe_single: assert property (
    state_r == sync_mem_pkg::ST_ACTIVE && tick |=>
    addr_strobe_or_read_en_n && sync_write_enable_n)
    else $error("strobe held past one interface cycle");
  chk_div_period: assert property (
    ct.div_clk && !div_prev_r && div_seen_r |->
    div_per_r == (clk_div_r == sync_mem_pkg::DIV_BY1 ? 4'h1 :
                  clk_div_r == sync_mem_pkg::DIV_BY2 ? 4'h3 : 4'h7))
    else $error("divided clock period wrong");
  chk_rise_launch: assert property (
    $fell(addr_strobe_or_read_en_n) |->
    (act_ctrl_r[sync_mem_pkg::CLKSEL_BIT] ?
     divided_out_clock : full_rate_out_clock))
    else $error("command not launched on a rising edge");
endmodule

// ### sync_mem_model.sv
// Behavioural synchronous memory on the far side of the controller pins.
module sync_mem_model #(
  parameter int AW = 20
) (
  // Clock
  input  wire logic          mclk,
  // Pins from the controller
  input  wire logic [AW-1:0] addr,
  input  wire logic [3:0]    be_n,
  input  wire logic          oe_n,
  input  wire logic [31:0]   wdata,
  input  wire logic          wdata_oe,
  // Data back to the controller
  output logic      [31:0]   rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [256];
  logic [31:0] junk = 32'h0F0F1E1E;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end

  // Sampled mid-period so the launch edge of the pins is never raced.
  always @(negedge mclk) begin
    junk <= {junk[30:0], ~junk[31]};
    if (wdata_oe) begin
      for (int b = 0; b < 4; b++) begin
        if (!be_n[b]) mem[addr[7:0]][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
  end

  // Outside output enable the bus shows a moving pattern, never stale data.
  always_comb rdata = oe_n ? junk : mem[addr[7:0]];
endmodule

// ### sync_memory_port_control_bench.sv
// Self-checking bench for the synchronous memory port controller.
module sync_memory_port_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NSP = 3;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, ext_data_i, ext_data_o;
  logic        pready, pslverr, fclk, dclk, as_n, oe_n, we_n, doe;
  logic        msel = 1'b0;
  logic [NSP-1:0] ce_n;
  logic [3:0]  be_n;
  logic [19:0] xa;
  int          err_total = 0;
  int          cmp_count = 0;
  int          nd = 1;
  logic [33:0] apb_q[$];
  int          ce_q[$], oe_q[$], dl_q[$];
  logic [31:0] seed = 32'h7;
  logic [31:0] shadow [256];

  initial forever #5 pclk = ~pclk;

  sync_memory_port_control #(.NUM_SPACES(NSP)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .full_rate_out_clock(fclk),
    .divided_out_clock(dclk), .space_chip_enable_n(ce_n),
    .byte_enable_n(be_n), .ext_address(xa),
    .addr_strobe_or_read_en_n(as_n), .sync_output_enable_n(oe_n),
    .sync_write_enable_n(we_n), .ext_data_i(ext_data_i),
    .ext_data_o(ext_data_o), .ext_data_oe(doe));

  sync_mem_model #(.AW(20)) mem_i (
    .mclk(msel ? dclk : fclk), .addr(xa), .be_n(be_n), .oe_n(oe_n),
    .wdata(ext_data_o), .wdata_oe(doe), .rdata(ext_data_i));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int take(ref int q[$]);
    if (q.size() == 0) return -1;
    return q.pop_front();
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic cmp_word(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) fail(m);
  endtask

  task automatic cmp_cyc(input int g, e, input string m);
    cmp_count++;
    if (g != e) fail(m);
  endtask

  // One APB transfer; the expectation {check, error, data} goes to the queue.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] ex, output logic [31:0] r);
    int i;
    apb_q.push_back(ex);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    if (i == 20) begin
      fail("apb timeout");
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    logic [31:0] r;
    apb(1'b1, a, d, {1'b0, e, 32'h0}, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, {1'b1, e, d}, r);
  endtask

  task automatic wait_idle();
    logic [31:0] r;
    int i;
    for (i = 0; i < 60; i++) begin
      apb(1'b0, sync_mem_pkg::OFS_STATUS, 32'h0, 34'h0, r);
      if (r[sync_mem_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 60) begin
      fail("busy stuck");
      wrap_up();
    end
  endtask

  // Divided clock period measured in pclk cycles between its 2nd and 3rd rise.
  task automatic clk_chk(input logic [1:0] code, input int n);
    int i, e0, k;
    logic p;
    wr(sync_mem_pkg::OFS_CLK_DIV, {30'h0, code});
    nd = n;
    e0 = 0;
    k = 0;
    p = 1'b1;
    for (i = 0; i < 60; i++) begin
      @(negedge pclk);
      if (dclk === 1'b1 && !p) k++;
      if (k == 2 && e0 == 0) e0 = i;
      if (k == 3) break;
      p = dclk;
    end
    cmp_cyc(i - e0, 2 * n, "divided clock period");
  endtask

  // One memory access; pin widths are predicted in pclk cycles.
  task automatic access(input int sp, input logic [6:0] c, input logic w,
                        input logic [3:0] be, input logic [7:0] a);
    int tk, lat;
    logic [31:0] d;
    tk = c[sync_mem_pkg::CLKSEL_BIT] ? 2 * nd : 2;
    msel <= c[sync_mem_pkg::CLKSEL_BIT];
    wr(sync_mem_pkg::OFS_SPACE_CTRL0 + 8'(4 * sp), {25'h0, c});
    wr(sync_mem_pkg::OFS_ADDR, {24'h0, a});
    if (w) begin
      d = xs();
      wr(sync_mem_pkg::OFS_WDATA, d);
      for (int b = 0; b < 4; b++) begin
        if (be[b]) shadow[a][8*b +: 8] = d[8*b +: 8];
      end
      dl_q.push_back(int'(c[3:2]) * tk);
      oe_q.push_back(tk);
      ce_q.push_back(tk);
    end else begin
      lat = (int'(c[1:0]) + 1) * tk;
      oe_q.push_back(lat);
      ce_q.push_back(c[sync_mem_pkg::CHIP_ENABLE_EXTEND_BIT] ? lat : tk);
    end
    wr(sync_mem_pkg::OFS_CMD, {24'h0, be, 1'b0, 2'(sp), w});
    wait_idle();
    if (!w) rd(sync_mem_pkg::OFS_RDATA, shadow[a]);
  endtask

  always @(posedge pclk) begin
    logic [33:0] ex;
    if (psel && penable && pready === 1'b1) begin
      ex = apb_q.size() ? apb_q.pop_front() : 34'h3FFFFFFFF;
      if (ex[33]) cmp_word(prdata, ex[31:0], "read data");
      cmp_word({31'h0, pslverr}, {31'h0, ex[32]}, "slave error");
    end
  end

  int   cc = 0;
  int   oc = 0;
  int   wc = 0;
  logic wa = 1'b0;
  logic wp = 1'b1;
  always @(posedge pclk) begin
    if (presetn && (&ce_n) === 1'b0) cc++;
    else if (cc > 0) begin
      cmp_cyc(cc, take(ce_q), "chip enable width");
      cc = 0;
    end
    if (presetn && (oe_n === 1'b0 || doe === 1'b1)) oc++;
    else if (oc > 0) begin
      cmp_cyc(oc, take(oe_q), "enable width");
      oc = 0;
    end
    if (we_n === 1'b0 && wp) begin
      wa = 1'b1;
      wc = 0;
    end
    if (wa && doe === 1'b1) begin
      cmp_cyc(wc, take(dl_q), "write latency");
      wa = 1'b0;
    end else if (wa) wc++;
    wp = we_n;
  end

  initial begin
    logic [31:0] x;
    logic [6:0]  c;
    for (int i = 0; i < 256; i++) shadow[i] = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(sync_mem_pkg::OFS_SPACE_CTRL0, 32'h0);
    rd(sync_mem_pkg::OFS_SPACE_CTRL0 + 8'h08, 32'h0);
    rd(sync_mem_pkg::OFS_CLK_DIV, 32'h0);
    rd(sync_mem_pkg::OFS_STATUS, 32'h0);
    rd(8'h40, 32'h0, 1'b1);
    wr(8'h44, xs(), 1'b1);
    clk_chk(2'h0, 1);
    clk_chk(2'h1, 2);
    clk_chk(2'h3, 4);
    clk_chk(2'h2, 4);
    for (int k = 0; k < 8; k++) begin
      c = {k[2], k[0], k[1], k[1:0], k[1:0]};
      x = xs();
      access(k % NSP, c, 1'b1, 4'hF, x[7:0]);
      access(k % NSP, c, 1'b0, 4'hF, x[7:0]);
    end
    access(1, 7'h05, 1'b1, 4'h5, x[7:0]);
    access(1, 7'h05, 1'b0, 4'hF, x[7:0]);
    // A command naming a space that does not exist must leave the port idle.
    wr(sync_mem_pkg::OFS_CMD, {24'h0, 4'hF, 1'b0, 2'h3, 1'b0});
    rd(sync_mem_pkg::OFS_STATUS, 32'h0);
    repeat (20) @(posedge pclk);
    if (ce_q.size() + oe_q.size() + dl_q.size() + apb_q.size() != 0)
      fail("expected activity missing");
    wrap_up();
  end
endmodule
